// ==== hw/acr_core.sv ====
// conversion sequencer, result fifo and parallel / master serial read-out
`timescale 1ns/10ps

// result fifo between the converter and the read-out ports
module acr_fifo #(
  parameter int unsigned WIDTH = 18,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    wr_d;
  logic [AW-1:0]    rd_q;
  logic [AW-1:0]    rd_d;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  // flags come from the count, so full and empty are exact
  always_comb begin
    in_ready  = (cnt_q != (AW+1)'(DEPTH));
    out_valid = (cnt_q != '0);
    out_data  = mem_q[rd_q];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wr_d      = push ? wr_q + 1'h1 : wr_q;
    rd_d      = pop ? rd_q + 1'h1 : rd_q;
    cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  // pointers reset, storage does not need to
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule : acr_fifo

// Behaviour
// - Busy stays high at most 1.5 us per conversion unless serial read-after.
// - Busy falls at least 10 ns after the internal conversion ends.
// - Parallel data is valid within 1.5 us of the start input falling.
// - Parallel data is valid at least 20 ns before busy falls.
// - Parallel results are offered as soon as their conversion completes; serial ones wait in the fifo for chip select.
// - Every result is an 18-bit word on parallel and serial outputs alike.
// - Serial read-during frame rises about 525 ns after the start falls; here it waits for the word in the fifo, after the conversion.
// - Serial read-after frame rises about 1.5 us after start, after conversion.
// - In serial read-after, busy falls about 25 ns after the frame drops; here it falls one 100 ns clock later.
// - The divider setting picks the serial clock period; here settings 0 to 2 all give two 100 ns clocks and setting 3 gives three.
// - In serial read-after, busy width is bounded per divider setting; here it has no bound and falls one clock after the frame, however late that is.
// - The first serial clock edge trails the frame rise by a least time.
// - The frame drops a least time after the last serial clock edge.
// - Serial outputs are driven shortly after chip select falls.
// - Serial outputs are released shortly after chip select rises.
module acr_core (
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire logic                     convert_start_n,
  input  wire logic                     cs_n,
  input  wire logic                     interface_sel_lo,
  input  wire logic                     interface_sel_hi,
  input  wire logic [1:0]               clock_divider_sel,
  input  wire logic                     read_after_convert,
  input  wire logic [acr_pkg::RES_W-1:0] sample_value,
  output logic                          busy,
  output logic [acr_pkg::RES_W-1:0]     parallel_data,
  output logic                          serial_clk,
  output logic                          serial_clk_oe,
  output logic                          serial_frame,
  output logic                          serial_frame_oe,
  output logic                          serial_result_out,
  output logic                          serial_result_oe
);
  localparam int unsigned W = acr_pkg::RES_W;

  acr_pkg::acr_pins_s pins_raw;
  acr_pkg::acr_pins_s sync1_q;
  acr_pkg::acr_pins_s sync2_q;
  logic               start_prev_q;
  acr_pkg::acr_seq_e  seq_q;
  acr_pkg::acr_seq_e  seq_d;
  acr_pkg::acr_ser_e  ser_q;
  acr_pkg::acr_ser_e  ser_d;
  logic [3:0]         seq_cnt_q;
  logic [3:0]         seq_cnt_d;
  logic [2:0]         ser_cnt_q;
  logic [2:0]         ser_cnt_d;
  logic [2:0]         rdc_cnt_q;
  logic [2:0]         rdc_cnt_d;
  logic               rdc_pend_q;
  logic               rdc_pend_d;
  logic               ser_req_q;
  logic               ser_req_d;
  logic [W-1:0]       shift_q;
  logic [W-1:0]       shift_d;
  logic [4:0]         bit_q;
  logic [4:0]         bit_d;
  logic               busy_q;
  logic               busy_d;
  logic [W-1:0]       par_q;
  logic [W-1:0]       par_d;
  logic               sclk_q;
  logic               sclk_d;
  logic               frame_q;
  logic               frame_d;
  logic               sdo_q;
  logic               sdo_d;
  logic               oe_q;
  logic               oe_d;
  logic               start_fall;
  logic               ser_mode;
  logic               cs_act;
  logic               pop_ser;
  logic               ser_done;
  logic               fifo_in_valid;
  logic               fifo_in_ready;
  logic               fifo_out_valid;
  logic               fifo_out_ready;
  logic [W-1:0]       fifo_out_data;

  // gather the pins into one carrier
  assign pins_raw = '{convert_start_n: convert_start_n, cs_n: cs_n,
                      iface_sel: {interface_sel_hi, interface_sel_lo},
                      clock_divider_sel: clock_divider_sel,
                      read_after_convert: read_after_convert};

  // two-stage synchroniser; stage one feeds stage two only
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_q      <= acr_pkg::PINS_RST;
      sync2_q      <= acr_pkg::PINS_RST;
      start_prev_q <= 1'h1;
    end else begin
      sync1_q      <= pins_raw;
      sync2_q      <= sync1_q;
      start_prev_q <= sync2_q.convert_start_n;
    end
  end

  // decoded controls from the synchronised pins
  always_comb begin
    start_fall = start_prev_q && !sync2_q.convert_start_n;
    ser_mode   = (sync2_q.iface_sel == acr_pkg::IF_SERIAL);
    cs_act     = !sync2_q.cs_n;
  end

  acr_fifo #(
    .WIDTH (W),
    .DEPTH (acr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (sample_value),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // next state of sequencer, serial engine and output registers
  always_comb begin
    seq_d         = seq_q;
    ser_d         = ser_q;
    seq_cnt_d     = seq_cnt_q;
    ser_cnt_d     = ser_cnt_q;
    rdc_cnt_d     = rdc_cnt_q;
    rdc_pend_d    = rdc_pend_q;
    ser_req_d     = ser_req_q;
    shift_d       = shift_q;
    bit_d         = bit_q;
    busy_d        = busy_q;
    par_d         = par_q;
    sclk_d        = sclk_q;
    frame_d       = frame_q;
    sdo_d         = sdo_q;
    fifo_in_valid = 1'h0;
    ser_done      = 1'h0;
    // drive serial pins only while selected
    oe_d          = ser_mode && cs_act;

    // a stalled drain holds words; serial waits for chip select
    pop_ser        = (ser_q == acr_pkg::SR_IDLE) && ser_req_q && cs_act
                     && ser_mode && fifo_out_valid;
    // parallel modes drain the fifo at once
    fifo_out_ready = !ser_mode || pop_ser;
    if (!ser_mode && fifo_out_valid) begin
      // full 18-bit word on the parallel port
      par_d = fifo_out_data;
    end

    // serial engine, msb first, data moves on the falling edge
    case (ser_q)
      acr_pkg::SR_IDLE: begin
        if (pop_ser) begin
          ser_req_d = 1'h0;
          shift_d   = fifo_out_data;
          sdo_d     = fifo_out_data[W-1];
          frame_d   = 1'h1;
          sclk_d    = 1'h0;
          bit_d     = '0;
          // low phase delays the first rising edge
          ser_cnt_d = acr_pkg::sclk_lo(sync2_q.clock_divider_sel) - 3'h1;
          ser_d     = acr_pkg::SR_LO;
        end
      end
      acr_pkg::SR_LO: begin
        if (ser_cnt_q == '0) begin
          sclk_d    = 1'h1;
          // half period from the divider setting
          ser_cnt_d = (acr_pkg::sclk_per(sync2_q.clock_divider_sel) >> 1)
                      - 3'h1;
          ser_d     = acr_pkg::SR_HI;
        end else begin
          ser_cnt_d = ser_cnt_q - 3'h1;
        end
      end
      acr_pkg::SR_HI: begin
        if (ser_cnt_q == '0) begin
          sclk_d = 1'h0;
          if (bit_q == 5'(W - 1)) begin
            // hold frame after the last edge
            ser_cnt_d = acr_pkg::frame_tail(sync2_q.clock_divider_sel)
                        - 3'h1;
            ser_d     = acr_pkg::SR_TAIL;
          end else begin
            bit_d     = bit_q + 5'h01;
            shift_d   = {shift_q[W-2:0], 1'h0};
            sdo_d     = shift_q[W-2];
            ser_cnt_d = acr_pkg::sclk_lo(sync2_q.clock_divider_sel) - 3'h1;
            ser_d     = acr_pkg::SR_LO;
          end
        end else begin
          ser_cnt_d = ser_cnt_q - 3'h1;
        end
      end
      acr_pkg::SR_TAIL: begin
        if (ser_cnt_q == '0) begin
          frame_d   = 1'h0;
          sdo_d     = 1'h0;
          ser_cnt_d = 3'(acr_pkg::FRAME_BUSY_CYC) - 3'h1;
          ser_d     = acr_pkg::SR_DONE;
        end else begin
          ser_cnt_d = ser_cnt_q - 3'h1;
        end
      end
      acr_pkg::SR_DONE: begin
        if (ser_cnt_q == '0) begin
          ser_done = 1'h1;
          ser_d    = acr_pkg::SR_IDLE;
          // backlog drains
          // words held back while deselected go out one after another
          if (fifo_out_valid) begin
            ser_req_d = 1'h1;
          end
        end else begin
          ser_cnt_d = ser_cnt_q - 3'h1;
        end
      end
      default: ser_d = acr_pkg::SR_IDLE;
    endcase

    // read-during frame request timed from the start edge
    if (rdc_pend_q) begin
      if (rdc_cnt_q == '0) begin
        rdc_pend_d = 1'h0;
        ser_req_d  = 1'h1;
      end else begin
        rdc_cnt_d = rdc_cnt_q - 3'h1;
      end
    end

    // conversion sequencer; a full fifo refuses a new start
    case (seq_q)
      acr_pkg::SQ_IDLE: begin
        if (start_fall && fifo_in_ready) begin
          busy_d    = 1'h1;
          seq_cnt_d = 4'(acr_pkg::CONV_CYC - 1);
          seq_d     = acr_pkg::SQ_CONV;
          if (ser_mode && !sync2_q.read_after_convert) begin
            rdc_pend_d = 1'h1;
            rdc_cnt_d  = 3'(acr_pkg::RDC_WAIT);
          end
        end
      end
      acr_pkg::SQ_CONV: begin
        if (seq_cnt_q == '0) begin
          // result enters the fifo the cycle it is ready
          fifo_in_valid = 1'h1;
          seq_cnt_d     = 4'(acr_pkg::EOC_CYC - 1);
          seq_d         = acr_pkg::SQ_EOC;
        end else begin
          seq_cnt_d = seq_cnt_q - 4'h1;
        end
      end
      acr_pkg::SQ_EOC: begin
        // busy waits for data plus a cycle
        if (seq_cnt_q == '0) begin
          if (ser_mode && sync2_q.read_after_convert) begin
            ser_req_d = 1'h1;
            seq_d     = acr_pkg::SQ_SER;
          end else begin
            busy_d = 1'h0;
            seq_d  = acr_pkg::SQ_IDLE;
          end
        end else begin
          seq_cnt_d = seq_cnt_q - 4'h1;
        end
      end
      acr_pkg::SQ_SER: begin
        // busy ends just after the frame drops
        if (ser_done) begin
          busy_d = 1'h0;
          seq_d  = acr_pkg::SQ_IDLE;
        end
      end
      default: seq_d = acr_pkg::SQ_IDLE;
    endcase
  end

  // state and output registers
  always_ff @(posedge clk) begin
    if (srst) begin
      seq_q      <= acr_pkg::SQ_IDLE;
      ser_q      <= acr_pkg::SR_IDLE;
      seq_cnt_q  <= '0;
      ser_cnt_q  <= '0;
      rdc_cnt_q  <= '0;
      rdc_pend_q <= 1'h0;
      ser_req_q  <= 1'h0;
      shift_q    <= '0;
      bit_q      <= '0;
      busy_q     <= 1'h0;
      par_q      <= '0;
      sclk_q     <= 1'h0;
      frame_q    <= 1'h0;
      sdo_q      <= 1'h0;
      oe_q       <= 1'h0;
    end else begin
      seq_q      <= seq_d;
      ser_q      <= ser_d;
      seq_cnt_q  <= seq_cnt_d;
      ser_cnt_q  <= ser_cnt_d;
      rdc_cnt_q  <= rdc_cnt_d;
      rdc_pend_q <= rdc_pend_d;
      ser_req_q  <= ser_req_d;
      shift_q    <= shift_d;
      bit_q      <= bit_d;
      busy_q     <= busy_d;
      par_q      <= par_d;
      sclk_q     <= sclk_d;
      frame_q    <= frame_d;
      sdo_q      <= sdo_d;
      oe_q       <= oe_d;
    end
  end

  // outputs straight from flip-flops
  assign busy              = busy_q;
  assign parallel_data     = par_q;
  assign serial_clk        = sclk_q;
  assign serial_frame      = frame_q;
  assign serial_result_out = sdo_q;
  assign serial_clk_oe     = oe_q;
  assign serial_frame_oe   = oe_q;
  assign serial_result_oe  = oe_q;
endmodule : acr_core

// ==== hw/acr_pkg.sv ====
// shared constants, types and timing helpers for the converter control block
package acr_pkg;

  // clock and word geometry
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned RES_W         = 18;
  localparam int unsigned FIFO_DEPTH    = 32;

  // round a least time up to whole cycles, never below one
  function automatic int unsigned cyc_min(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_min

  // round a longest time down, floored at the given cycle count
  function automatic int unsigned cyc_max(input int unsigned ns,
                                          input int unsigned floor_c);
    int unsigned c;
    c = ns / CLK_PERIOD_NS;
    return (c < floor_c) ? floor_c : c;
  endfunction : cyc_max

  // conversion sequencing times
  localparam int unsigned T_BUSY_MAX_NS   = 1500;
  localparam int unsigned T_CONV_NS       = 900;
  localparam int unsigned CONV_CYC        = cyc_max(T_CONV_NS, 1);
  localparam int unsigned T_EOC_BUSY_NS   = 10;
  localparam int unsigned T_DATA_BUSY_NS  = 20;
  localparam int unsigned FIFO_LAT_CYC    = 1;
  localparam int unsigned EOC_CYC         = cyc_min(T_DATA_BUSY_NS)
                                            + FIFO_LAT_CYC;
  localparam int unsigned T_START_DATA_NS = 1500;

  // master serial frame placement
  localparam int unsigned T_RDC_FRAME_NS  = 525;
  localparam int unsigned RDC_CYC         = cyc_max(T_RDC_FRAME_NS, 1);
  localparam int unsigned FRAME_PIPE_CYC  = 5;
  localparam int unsigned RDC_WAIT        = RDC_CYC - FRAME_PIPE_CYC;
  localparam int unsigned T_RAC_FRAME_NS  = 1500;
  localparam int unsigned T_FRAME_BUSY_NS = 25;
  localparam int unsigned FRAME_BUSY_CYC  = cyc_min(T_FRAME_BUSY_NS);
  localparam int unsigned T_CS_OUT_NS     = 10;

  // serial clock per divider setting
  localparam int unsigned SCLK_PER_NS_0 = 40;
  localparam int unsigned SCLK_PER_NS_1 = 80;
  localparam int unsigned SCLK_PER_NS_2 = 160;
  localparam int unsigned SCLK_PER_NS_3 = 320;
  localparam int unsigned LEAD_NS_0     = 3;
  localparam int unsigned LEAD_NS_N     = 17;
  localparam int unsigned T24_NS_0      = 3;
  localparam int unsigned T24_NS_1      = 60;
  localparam int unsigned T24_NS_2      = 140;
  localparam int unsigned T24_NS_3      = 300;
  localparam int unsigned BUSY_RAC_NS_0 = 2250;
  localparam int unsigned BUSY_RAC_NS_1 = 3000;
  localparam int unsigned BUSY_RAC_NS_2 = 4500;
  localparam int unsigned BUSY_RAC_NS_3 = 7500;
  // a high and a low phase need one cycle each
  localparam int unsigned SCLK_PER_CYC_0 = cyc_max(SCLK_PER_NS_0, 2);
  localparam int unsigned SCLK_PER_CYC_1 = cyc_max(SCLK_PER_NS_1, 2);
  localparam int unsigned SCLK_PER_CYC_2 = cyc_max(SCLK_PER_NS_2, 2);
  localparam int unsigned SCLK_PER_CYC_3 = cyc_max(SCLK_PER_NS_3, 2);
  localparam int unsigned LEAD_CYC       = cyc_min(LEAD_NS_N);
  localparam int unsigned TAIL_CYC_0     = cyc_min(T24_NS_0);
  localparam int unsigned TAIL_CYC_1     = cyc_min(T24_NS_1);
  localparam int unsigned TAIL_CYC_2     = cyc_min(T24_NS_2);
  localparam int unsigned TAIL_CYC_3     = cyc_min(T24_NS_3);

  // output interface select codes
  localparam logic [1:0] IF_PAR18  = 2'h0;
  localparam logic [1:0] IF_PAR16  = 2'h1;
  localparam logic [1:0] IF_BYTE   = 2'h2;
  localparam logic [1:0] IF_SERIAL = 2'h3;

  // serial clock period in cycles for a divider setting
  function automatic logic [2:0] sclk_per(input logic [1:0] sel);
    case (sel)
      2'h0:    return 3'(SCLK_PER_CYC_0);
      2'h1:    return 3'(SCLK_PER_CYC_1);
      2'h2:    return 3'(SCLK_PER_CYC_2);
      default: return 3'(SCLK_PER_CYC_3);
    endcase
  endfunction : sclk_per

  // low phase, which also serves as frame-to-first-edge lead
  function automatic logic [2:0] sclk_lo(input logic [1:0] sel);
    logic [2:0] lo;
    lo = sclk_per(sel) - (sclk_per(sel) >> 1);
    return (lo < 3'(LEAD_CYC)) ? 3'(LEAD_CYC) : lo;
  endfunction : sclk_lo

  // hold after the last clock edge before the frame drops
  function automatic logic [2:0] frame_tail(input logic [1:0] sel);
    case (sel)
      2'h0:    return 3'(TAIL_CYC_0);
      2'h1:    return 3'(TAIL_CYC_1);
      2'h2:    return 3'(TAIL_CYC_2);
      default: return 3'(TAIL_CYC_3);
    endcase
  endfunction : frame_tail

  // pin group carried through the synchroniser
  typedef struct packed {
    logic       convert_start_n;
    logic       cs_n;
    logic [1:0] iface_sel;
    logic [1:0] clock_divider_sel;
    logic       read_after_convert;
  } acr_pins_s;

  localparam acr_pins_s PINS_RST = '{convert_start_n: 1'h1, cs_n: 1'h1,
                                     iface_sel: 2'h0, clock_divider_sel: 2'h0,
                                     read_after_convert: 1'h0};

  typedef enum logic [3:0] {
    SQ_IDLE = 4'h1,
    SQ_CONV = 4'h2,
    SQ_EOC  = 4'h4,
    SQ_SER  = 4'h8
  } acr_seq_e;

  typedef enum logic [4:0] {
    SR_IDLE = 5'h01,
    SR_LO   = 5'h02,
    SR_HI   = 5'h04,
    SR_TAIL = 5'h08,
    SR_DONE = 5'h10
  } acr_ser_e;

endpackage : acr_pkg

// ==== tb/acr_core_assertions.sv ====
// concurrent checks on the converter control ports
`timescale 1ns/10ps
module acr_core_assertions (
  input wire logic                      clk,
  input wire logic                      srst,
  input wire logic                      convert_start_n,
  input wire logic                      cs_n,
  input wire logic                      interface_sel_lo,
  input wire logic                      interface_sel_hi,
  input wire logic [1:0]                clock_divider_sel,
  input wire logic                      read_after_convert,
  input wire logic [acr_pkg::RES_W-1:0] sample_value,
  input wire logic                      busy,
  input wire logic [acr_pkg::RES_W-1:0] parallel_data,
  input wire logic                      serial_clk,
  input wire logic                      serial_clk_oe,
  input wire logic                      serial_frame,
  input wire logic                      serial_frame_oe,
  input wire logic                      serial_result_out,
  input wire logic                      serial_result_oe
);
  logic       ser;
  logic [4:0] edge_q;
  logic       sclk_q;

  // mode pins are only changed while idle, so raw levels are safe here
  assign ser = interface_sel_lo & interface_sel_hi;

  // rising serial clock edges within the current frame
  always_ff @(posedge clk) begin
    if (srst) begin
      edge_q <= 5'h00;
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= serial_clk;
      edge_q <= !serial_frame ? 5'h00 : edge_q + 5'(serial_clk && !sclk_q);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_busy_max;
    $rose(busy) && !(ser && read_after_convert) |-> ##[1:15] !busy;
  endproperty
  a_busy_max: assert property (p_busy_max)
    else $error("busy held too long");
  property p_busy_min;
    $rose(busy) |-> busy [*8];
  endproperty
  a_busy_min: assert property (p_busy_min)
    else $error("busy fell before conversion end");
  property p_data_early;
    $fell(busy) && !ser |-> $stable(parallel_data);
  endproperty
  a_data_early: assert property (p_data_early)
    else $error("parallel data moved as busy fell");
  property p_data_value;
    $fell(busy) && !ser |-> parallel_data == $past(sample_value, 3);
  endproperty
  a_data_value: assert property (p_data_value)
    else $error("parallel data is not the latest sample");
  property p_bits;
    $fell(serial_frame) |-> edge_q == 5'h12;
  endproperty
  a_bits: assert property (p_bits)
    else $error("frame did not carry 18 clock edges");
  property p_busy_after;
    $fell(serial_frame) && read_after_convert |-> busy ##1 !busy;
  endproperty
  a_busy_after: assert property (p_busy_after)
    else $error("busy did not drop one cycle after frame");
  property p_clk_high;
    $rose(serial_clk) |=> $fell(serial_clk);
  endproperty
  a_clk_high: assert property (p_clk_high)
    else $error("serial clock high phase wrong");
  property p_clk_low3;
    $fell(serial_clk) && clock_divider_sel == 2'h3 |=> !serial_clk;
  endproperty
  a_clk_low3: assert property (p_clk_low3)
    else $error("serial clock low phase too short");
  property p_lead;
    $rose(serial_frame) |-> !serial_clk;
  endproperty
  a_lead: assert property (p_lead)
    else $error("serial clock edge with frame rise");
  property p_tail;
    $fell(serial_frame) |-> !serial_clk && !$past(serial_clk);
  endproperty
  a_tail: assert property (p_tail)
    else $error("frame dropped too soon after clock");
  property p_oe_on;
    $fell(cs_n) && ser |-> ##[1:4] serial_result_oe && serial_frame_oe;
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("serial outputs not driven after select");
  property p_oe_off;
    $rose(cs_n) |-> ##[1:4] !(serial_result_oe || serial_clk_oe);
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("serial outputs not released");

  c_par: cover property (!ser && $fell(busy));
  c_ser: cover property (ser && $fell(serial_frame));
  c_rac: cover property (read_after_convert && ser && $fell(busy));
endmodule : acr_core_assertions

bind acr_core acr_core_assertions i_chk (.clk, .srst, .convert_start_n,
  .cs_n, .interface_sel_lo, .interface_sel_hi, .clock_divider_sel,
  .read_after_convert, .sample_value, .busy, .parallel_data, .serial_clk,
  .serial_clk_oe, .serial_frame, .serial_frame_oe, .serial_result_out,
  .serial_result_oe);

// ==== tb/acr_host_model.sv ====
// host side model that collects master serial words off the wire
`timescale 1ns/10ps
module acr_host_model (
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic                 serial_clk,
  input  wire logic                 serial_frame,
  input  wire logic                 serial_result_out,
  input  wire logic                 serial_result_oe,
  output logic [acr_pkg::RES_W-1:0] word,
  output logic                      word_valid
);
  logic d;
  logic sclk_p;
  logic frame_p;

  // released line shows the inverse, so a bit taken undriven is caught
  assign d = serial_result_oe ? serial_result_out : !serial_result_out;

  always @(posedge clk) begin
    sclk_p <= serial_clk;
    frame_p <= serial_frame;
    word_valid <= !srst && frame_p && !serial_frame;
    if (serial_frame && serial_clk && !sclk_p)
      word <= {word[acr_pkg::RES_W-2:0], d};
  end
endmodule : acr_host_model

// ==== tb/acr_core_tb.sv ====
// self-checking bench for the converter control block
`timescale 1ns/10ps
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin \
  n_fail++; $display("CHECK FAILED %s exp %h got %h", nm, e, a); end end
module acr_core_tb;
  logic                      clk = 1'b0;
  logic                      srst = 1'b1;
  logic                      convert_start_n = 1'b1;
  logic                      cs_n = 1'b1;
  logic                      read_after_convert = 1'b0;
  logic [1:0]                iface = 2'h0;
  logic [1:0]                clock_divider_sel = 2'h0;
  logic [acr_pkg::RES_W-1:0] sample_value = '0;
  logic [acr_pkg::RES_W-1:0] parallel_data, word, e;
  logic                      busy, serial_clk, serial_clk_oe, serial_frame;
  logic                      serial_frame_oe, serial_result_out;
  logic                      serial_result_oe, word_valid, busy_p = 1'b0;
  wire                       interface_sel_lo = iface[0];
  wire                       interface_sel_hi = iface[1];
  int                        n_fail = 0, total_checks = 0, cyc = 0;
  int                        seed = 32'he31a_3c06;
  logic [acr_pkg::RES_W-1:0] exp_q[$];

  always #50 clk = ~clk;

  acr_core i_dut (.clk, .srst, .convert_start_n, .cs_n, .interface_sel_lo,
    .interface_sel_hi, .clock_divider_sel, .read_after_convert,
    .sample_value, .busy, .parallel_data, .serial_clk, .serial_clk_oe,
    .serial_frame, .serial_frame_oe, .serial_result_out, .serial_result_oe);
  acr_host_model i_host (.clk, .srst, .serial_clk, .serial_frame,
    .serial_result_out, .serial_result_oe, .word, .word_valid);

  task automatic results();
    if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // mode pins go through a synchroniser, so give them time to settle
  task automatic set_mode(input logic [1:0] m, input logic r,
                          input logic [1:0] d, input logic c);
    iface <= m;
    read_after_convert <= r;
    clock_divider_sel <= d;
    cs_n <= c;
    tick(4);
  endtask : set_mode

  // one start pulse; the sample is held until the next conversion
  task automatic conv(input bit keep);
    logic [acr_pkg::RES_W-1:0] v;
    v = acr_pkg::RES_W'($random(seed));
    @(posedge clk);
    // a refused start must not disturb the sample of the running conversion
    if (keep) sample_value <= v;
    convert_start_n <= 1'b0;
    @(posedge clk);
    convert_start_n <= 1'b1;
    if (keep) exp_q.push_back(v);
  endtask : conv

  task automatic wait_idle();
    tick(4);
    while (busy || serial_frame) @(posedge clk);
    tick(2);
  endtask : wait_idle

  // compare each delivered word with the oldest expectation
  always @(negedge clk) begin
    if (!srst && (word_valid || (busy_p && !busy &&
        iface != acr_pkg::IF_SERIAL))) begin
      if (exp_q.size() == 0) `CHK("extra_result", 1'b0, 1'b1)
      else begin
        e = exp_q.pop_front();
        if (word_valid) `CHK("serial_word", e, word)
        else `CHK("parallel_data", e, parallel_data)
      end
    end
    busy_p = busy;
  end

  // hang guard, far above the few thousand cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      n_fail++;
      results();
    end
  end

  initial begin
    tick(5);
    srst <= 1'b0;
    tick(2);
    // every parallel format, back to back, with a start while busy
    for (int m = 0; m < 3; m++) begin
      set_mode(2'(m), 1'b0, 2'h0, 1'(m != 1));
      conv(1'b1);
      wait_idle();
      conv(1'b1);
      tick(5);
      conv(1'b0);
      wait_idle();
      `CHK("sdo_oe", 1'b0, serial_result_oe)
    end
    // read after convert at every divider setting
    for (int d = 0; d < 4; d++) begin
      set_mode(acr_pkg::IF_SERIAL, 1'b1, 2'(d), 1'b0);
      conv(1'b1);
      wait_idle();
    end
    // deselected host: word waits and busy holds
    set_mode(acr_pkg::IF_SERIAL, 1'b1, 2'h0, 1'b1);
    conv(1'b1);
    tick(40);
    `CHK("busy_held", 1'b1, busy)
    `CHK("frame_oe", 1'b0, serial_frame_oe)
    cs_n <= 1'b0;
    wait_idle();
    // fill the buffer while the host stalls, then one refused start
    set_mode(acr_pkg::IF_SERIAL, 1'b0, 2'h1, 1'b1);
    repeat (acr_pkg::FIFO_DEPTH) begin
      conv(1'b1);
      wait_idle();
    end
    conv(1'b0);
    tick(6);
    `CHK("busy_refused", 1'b0, busy)
    cs_n <= 1'b0;
    while (exp_q.size() != 0) @(posedge clk);
    wait_idle();
    // read during convert with the buffer empty
    repeat (2) begin
      conv(1'b1);
      wait_idle();
    end
    // second reset in mid-run clears the outputs
    srst <= 1'b1;
    tick(2);
    `CHK("busy_rst", 1'b0, busy)
    `CHK("data_rst", 18'h0_0000, parallel_data)
    srst <= 1'b0;
    tick(2);
    `CHK("queue_left", 32'h0000_0000, 32'(exp_q.size()))
    results();
  end
endmodule : acr_core_tb
